// >>> core/tu_oh_pkg.sv
// shared constants for the add-side tributary overhead inserter
// ****************************************************************
// What this block does
// RQ1: generation off sends traffic; on sends unequipped; with supervisory adds trace and parity.
// RQ2: tandem off sends the written N2 value whatever the size select holds.
// RQ3: tandem on, size 0: J2 and N2 share trace memory, 16 bytes each.
// RQ4: tandem on, size 1: 64-byte J2; N2 value sent 16 times with alignment.
// RQ5: message type 0 sends 16 or 64 byte J2; type 1 sends all zeros.
// RQ6: outgoing V5 bit 4 equals the remote-failure control bit.
// RQ7: three-bit payload defect sends K4 code 010 and V5 bit 8 zero.
// RQ8: three-bit connectivity defect sends K4 code 110 and V5 bit 8 one.
// RQ9: three-bit server defect sends K4 code 101 and V5 bit 8 one.
// RQ10: single-bit mode server defect drives V5 bit 8 high.
// RQ11: parity error control set inverts the two parity bits for one frame.
// RQ12: software clears then sets the control again; only a rise injects.
// RQ13: tandem unequipped control sends a zero tandem byte, only with tandem on.
// RQ14: V5 source control set sends the written V5 register value.
// RQ15: payload and connectivity controls are ignored in single-bit mode.
// RQ16: several three-bit controls set: server beats connectivity beats payload.
// ****************************************************************
package tu_oh_pkg;

	// ****************************************************************
	// register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [7:0] IDX_V5_VALUE = 8'h60;
	localparam logic [7:0] IDX_N2_VALUE = 8'h61;
	localparam logic [7:0] IDX_OH_CTRL = 8'h63;
	localparam logic [7:0] IDX_ALARM_CTRL = 8'h64;
	localparam logic [7:0] IDX_CONFIG = 8'h70;
	localparam logic [7:0] IDX_STATUS = 8'h71;
	localparam logic [1:0] IDX_TRACE_TOP = 2'h2;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int B_UQ_GEN = 4;
	localparam int B_UQ_SUP = 3;
	localparam int B_TC_EN = 2;
	localparam int B_TRACE_ZERO = 1;
	localparam int B_TRACE_SIZE = 0;
	localparam int B_RFI = 7;
	localparam int B_RDI_PAY = 6;
	localparam int B_RDI_CONN = 5;
	localparam int B_RDI_SERV = 4;
	localparam int B_PAR_ERR = 3;
	localparam int B_TC_UQ = 2;
	localparam int B_V5_SRC = 0;
	localparam int B_RDI3_DIS = 0;
	localparam logic [7:0] ALARM_MASK = 8'hfd;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ****************************************************************
	// codes
	// ****************************************************************
	localparam logic [2:0] K4_NONE = 3'h0;
	localparam logic [2:0] K4_PAYLOAD = 3'h2;
	localparam logic [2:0] K4_CONN = 3'h6;
	localparam logic [2:0] K4_SERVER = 3'h5;
	localparam logic [15:0] N2_ALIGN = 16'hfffe;
	localparam logic [7:0] TC_UNEQ_BYTE = 8'h00;
	localparam logic [5:0] SHORT_LEN_MASK = 6'h0f;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		KIND_PAYLOAD = 3'h0,
		KIND_V5 = 3'h1,
		KIND_J2 = 3'h2,
		KIND_N2 = 3'h3,
		KIND_K4 = 3'h4
	} oh_kind_t;

	typedef enum logic [1:0] {
		WS_IDLE = 2'h0,
		WS_GOTA = 2'h1,
		WS_RESP = 2'h3,
		WS_GOTD = 2'h2
	} wr_state_t;

endpackage

// >>> core/rdi_encode.sv
// remote defect code selection for K4 and V5
`timescale 1ns/1ps
module rdi_encode (
	input wire logic threeBit,
	input wire logic server,
	input wire logic conn,
	input wire logic payload,
	output logic [2:0] k4Code,
	output logic v5Bit8
);
	always_comb begin
		k4Code = tu_oh_pkg::K4_NONE;
		v5Bit8 = 1'b0;
		if (threeBit) begin
			if (server) begin
				k4Code = tu_oh_pkg::K4_SERVER; // see RQ9 see RQ16
				v5Bit8 = 1'b1;
			end else if (conn) begin
				k4Code = tu_oh_pkg::K4_CONN; // see RQ8
				v5Bit8 = 1'b1;
			end else if (payload) begin
				k4Code = tu_oh_pkg::K4_PAYLOAD; // see RQ7
				v5Bit8 = 1'b0;
			end
		end else begin
			v5Bit8 = server; // see RQ10 see RQ15
		end
	end
endmodule

// >>> core/tu_oh_insert.sv
// add-side tributary overhead inserter with its register slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tu_oh_insert #(
	parameter int ADDR_W = 10,
	parameter int TRACE_DEPTH = 64
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic awvalid,
	input wire logic [ADDR_W-1:0] awaddr,
	output logic awready,
	input wire logic wvalid,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic wready,
	output logic bvalid,
	output logic [1:0] bresp,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic [ADDR_W-1:0] araddr,
	output logic arready,
	output logic rvalid,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic rready,
	input wire logic ohReq,
	input wire logic [2:0] ohKind,
	input wire logic [1:0] bipIn,
	input wire logic [7:0] payloadIn,
	output logic txValid,
	output logic [7:0] txByte
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (ADDR_W < 10) begin : g_bad_addr
		$error("address too narrow for register map");
	end
	if (TRACE_DEPTH != 64) begin : g_bad_depth
		$error("trace memory must hold 64 bytes");
	end

	// ****************************************************************
	// declarations
	// ****************************************************************
	tu_oh_pkg::wr_state_t wrState_ff;
	tu_oh_pkg::wr_state_t nxt_wrState;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [7:0] awIdx_ff;
	logic [7:0] wData_ff;
	logic wStrb_ff;
	logic [7:0] v5Val_ff;
	logic [7:0] n2Val_ff;
	logic [7:0] ohCtrl_ff;
	logic [7:0] alarmCtrl_ff;
	logic [7:0] cfg_ff;
	logic [7:0] traceMem_ff [TRACE_DEPTH];
	logic parPrev_ff;
	logic parPending_ff;
	logic [5:0] j2Ptr_ff;
	logic [3:0] n2Ptr_ff;
	logic txValid_ff;
	logic [7:0] txByte_ff;
	logic [7:0] nxt_txByte;
	logic awHs;
	logic wHs;
	logic doWrite;
	logic [7:0] wrIdx;
	logic [7:0] wrByte;
	logic wrLane;
	logic [7:0] rdIdx;
	logic parRise;
	logic v5Built;
	logic uqGen;
	logic uqSup;
	logic uqPlain;
	logic tcEn;
	logic traceSize;
	logic threeBit;
	logic [2:0] k4Code;
	logic v5Bit8;
	logic [5:0] j2Len;

	// ****************************************************************
	// decoding
	// ****************************************************************
	function automatic logic isMapped(input logic [7:0] idx);
		isMapped = (idx == tu_oh_pkg::IDX_V5_VALUE) || (idx == tu_oh_pkg::IDX_N2_VALUE)
			|| (idx == tu_oh_pkg::IDX_OH_CTRL) || (idx == tu_oh_pkg::IDX_ALARM_CTRL)
			|| (idx == tu_oh_pkg::IDX_CONFIG) || (idx == tu_oh_pkg::IDX_STATUS)
			|| (idx[7:6] == tu_oh_pkg::IDX_TRACE_TOP);
	endfunction

	assign uqGen = ohCtrl_ff[tu_oh_pkg::B_UQ_GEN];
	assign uqSup = ohCtrl_ff[tu_oh_pkg::B_UQ_SUP];
	assign uqPlain = uqGen && !uqSup;
	assign tcEn = ohCtrl_ff[tu_oh_pkg::B_TC_EN];
	assign traceSize = ohCtrl_ff[tu_oh_pkg::B_TRACE_SIZE];
	assign threeBit = !cfg_ff[tu_oh_pkg::B_RDI3_DIS];
	assign j2Len = traceSize ? 6'h3f : tu_oh_pkg::SHORT_LEN_MASK;

	rdi_encode u_rdi (
		.threeBit(threeBit),
		.server(alarmCtrl_ff[tu_oh_pkg::B_RDI_SERV]),
		.conn(alarmCtrl_ff[tu_oh_pkg::B_RDI_CONN]),
		.payload(alarmCtrl_ff[tu_oh_pkg::B_RDI_PAY]),
		.k4Code(k4Code),
		.v5Bit8(v5Bit8)
	);

	// ****************************************************************
	// write channel
	// ****************************************************************
	assign awHs = awvalid && awready_ff;
	assign wHs = wvalid && wready_ff;
	assign wrIdx = awHs ? awaddr[9:2] : awIdx_ff;
	assign wrByte = wHs ? wdata[7:0] : wData_ff;
	assign wrLane = wHs ? wstrb[0] : wStrb_ff;

	always_comb begin
		nxt_wrState = wrState_ff;
		doWrite = 1'b0;
		case (wrState_ff)
			tu_oh_pkg::WS_IDLE: begin
				if (awHs && wHs) begin
					nxt_wrState = tu_oh_pkg::WS_RESP;
					doWrite = 1'b1;
				end else if (awHs) begin
					nxt_wrState = tu_oh_pkg::WS_GOTA;
				end else if (wHs) begin
					nxt_wrState = tu_oh_pkg::WS_GOTD;
				end
			end
			tu_oh_pkg::WS_GOTA: begin
				if (wHs) begin
					nxt_wrState = tu_oh_pkg::WS_RESP;
					doWrite = 1'b1;
				end
			end
			tu_oh_pkg::WS_GOTD: begin
				if (awHs) begin
					nxt_wrState = tu_oh_pkg::WS_RESP;
					doWrite = 1'b1;
				end
			end
			tu_oh_pkg::WS_RESP: begin
				if (bready) begin
					nxt_wrState = tu_oh_pkg::WS_IDLE;
				end
			end
			default: nxt_wrState = tu_oh_pkg::WS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wrState_ff <= tu_oh_pkg::WS_IDLE;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= tu_oh_pkg::RESP_OKAY;
			awIdx_ff <= tu_oh_pkg::RST_BYTE;
			wData_ff <= tu_oh_pkg::RST_BYTE;
			wStrb_ff <= 1'b0;
		end else begin
			wrState_ff <= nxt_wrState;
			awready_ff <= (nxt_wrState == tu_oh_pkg::WS_IDLE)
				|| (nxt_wrState == tu_oh_pkg::WS_GOTD);
			wready_ff <= (nxt_wrState == tu_oh_pkg::WS_IDLE)
				|| (nxt_wrState == tu_oh_pkg::WS_GOTA);
			bvalid_ff <= (nxt_wrState == tu_oh_pkg::WS_RESP);
			if (awHs) begin
				awIdx_ff <= awaddr[9:2];
			end
			if (wHs) begin
				wData_ff <= wdata[7:0];
				wStrb_ff <= wstrb[0];
			end
			if (doWrite) begin
				bresp_ff <= isMapped(wrIdx) ? tu_oh_pkg::RESP_OKAY : tu_oh_pkg::RESP_DECERR;
			end
		end
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			v5Val_ff <= tu_oh_pkg::RST_BYTE;
			n2Val_ff <= tu_oh_pkg::RST_BYTE;
			ohCtrl_ff <= tu_oh_pkg::RST_BYTE;
			alarmCtrl_ff <= tu_oh_pkg::RST_BYTE;
			cfg_ff <= tu_oh_pkg::RST_BYTE;
		end else if (doWrite && wrLane) begin
			case (wrIdx)
				tu_oh_pkg::IDX_V5_VALUE: v5Val_ff <= wrByte;
				tu_oh_pkg::IDX_N2_VALUE: n2Val_ff <= wrByte;
				tu_oh_pkg::IDX_OH_CTRL: ohCtrl_ff <= wrByte;
				tu_oh_pkg::IDX_ALARM_CTRL: alarmCtrl_ff <= wrByte & tu_oh_pkg::ALARM_MASK;
				tu_oh_pkg::IDX_CONFIG: cfg_ff <= {7'h00, wrByte[tu_oh_pkg::B_RDI3_DIS]};
				default: ;
			endcase
		end
	end

	// trace memory is write-only storage filled by software
	always_ff @(posedge mclk) begin
		if (doWrite && wrLane && (wrIdx[7:6] == tu_oh_pkg::IDX_TRACE_TOP)) begin
			traceMem_ff[wrIdx[5:0]] <= wrByte;
		end
	end

	// ****************************************************************
	// read channel
	// ****************************************************************
	assign rdIdx = araddr[9:2];

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= tu_oh_pkg::RESP_OKAY;
		end else begin
			if (arvalid && arready_ff) begin
				rvalid_ff <= 1'b1;
				arready_ff <= 1'b0;
				rresp_ff <= isMapped(rdIdx) ? tu_oh_pkg::RESP_OKAY : tu_oh_pkg::RESP_DECERR;
				case (rdIdx)
					tu_oh_pkg::IDX_V5_VALUE: rdata_ff <= {24'h000000, v5Val_ff};
					tu_oh_pkg::IDX_N2_VALUE: rdata_ff <= {24'h000000, n2Val_ff};
					tu_oh_pkg::IDX_OH_CTRL: rdata_ff <= {24'h000000, ohCtrl_ff};
					tu_oh_pkg::IDX_ALARM_CTRL: rdata_ff <= {24'h000000, alarmCtrl_ff};
					tu_oh_pkg::IDX_CONFIG: rdata_ff <= {24'h000000, cfg_ff};
					tu_oh_pkg::IDX_STATUS:
						rdata_ff <= {18'h00000, n2Ptr_ff, j2Ptr_ff, 3'h0, parPending_ff};
					default: rdata_ff <= 32'h0000_0000;
				endcase
			end else if (rvalid_ff) begin
				if (rready) begin
					rvalid_ff <= 1'b0;
					arready_ff <= 1'b1;
				end
			end else begin
				arready_ff <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// parity error injection
	// ****************************************************************
	assign parRise = alarmCtrl_ff[tu_oh_pkg::B_PAR_ERR] && !parPrev_ff; // see RQ12
	assign v5Built = ohReq && (ohKind == tu_oh_pkg::KIND_V5) && !uqPlain
		&& !alarmCtrl_ff[tu_oh_pkg::B_V5_SRC];

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			parPrev_ff <= 1'b0;
			parPending_ff <= 1'b0;
		end else begin
			parPrev_ff <= alarmCtrl_ff[tu_oh_pkg::B_PAR_ERR];
			if (parRise) begin
				parPending_ff <= 1'b1;
			end else if (v5Built) begin
				parPending_ff <= 1'b0; // see RQ11
			end
		end
	end

	// ****************************************************************
	// overhead byte selection
	// ****************************************************************
	always_comb begin
		nxt_txByte = payloadIn;
		if (uqPlain) begin
			nxt_txByte = 8'h00; // see RQ1
		end else begin
			case (ohKind)
				tu_oh_pkg::KIND_V5: begin
					if (alarmCtrl_ff[tu_oh_pkg::B_V5_SRC]) begin
						nxt_txByte = v5Val_ff; // see RQ14
					end else begin
						nxt_txByte[7:6] = parPending_ff ? ~bipIn : bipIn; // see RQ11
						nxt_txByte[5] = 1'b0;
						nxt_txByte[4] = alarmCtrl_ff[tu_oh_pkg::B_RFI]; // see RQ6
						nxt_txByte[3:1] = uqGen ? 3'h0 : v5Val_ff[3:1];
						nxt_txByte[0] = v5Bit8; // see RQ7 see RQ8 see RQ9 see RQ10
					end
				end
				tu_oh_pkg::KIND_J2: begin
					if (ohCtrl_ff[tu_oh_pkg::B_TRACE_ZERO]) begin
						nxt_txByte = 8'h00; // see RQ5
					end else begin
						nxt_txByte = traceMem_ff[j2Ptr_ff & j2Len]; // see RQ5 see RQ1
					end
				end
				tu_oh_pkg::KIND_N2: begin
					if (uqGen) begin
						nxt_txByte = 8'h00; // see RQ1
					end else if (!tcEn) begin
						nxt_txByte = n2Val_ff; // see RQ2
					end else if (alarmCtrl_ff[tu_oh_pkg::B_TC_UQ]) begin
						nxt_txByte = tu_oh_pkg::TC_UNEQ_BYTE; // see RQ13
					end else if (!traceSize) begin
						nxt_txByte = traceMem_ff[{2'h1, n2Ptr_ff}]; // see RQ3
					end else begin
						nxt_txByte = {n2Val_ff[7:2], tu_oh_pkg::N2_ALIGN[4'hf - n2Ptr_ff], 1'b0};
					end
				end
				tu_oh_pkg::KIND_K4: begin
					nxt_txByte = {4'h0, k4Code, 1'b0}; // see RQ15
				end
				default: nxt_txByte = uqGen ? 8'h00 : payloadIn;
			endcase
		end
	end

	// ****************************************************************
	// output and trace pointers
	// ****************************************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			txValid_ff <= 1'b0;
			txByte_ff <= tu_oh_pkg::RST_BYTE;
			j2Ptr_ff <= 6'h00;
			n2Ptr_ff <= 4'h0;
		end else begin
			txValid_ff <= ohReq;
			if (ohReq) begin
				txByte_ff <= nxt_txByte;
			end
			if (ohReq && (ohKind == tu_oh_pkg::KIND_J2)) begin
				j2Ptr_ff <= (j2Ptr_ff + 6'h01) & j2Len; // see RQ3 see RQ4
			end
			if (ohReq && (ohKind == tu_oh_pkg::KIND_N2)) begin
				n2Ptr_ff <= n2Ptr_ff + 4'h1; // see RQ4
			end
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign txValid = txValid_ff;
	assign txByte = txByte_ff;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_unequipped_zero: assert property (ohReq && uqPlain |=> txByte_ff == 8'h00) // see RQ1
		else $error("plain unequipped byte not zero");
	a_n2_written: assert property (ohReq && ohKind == tu_oh_pkg::KIND_N2 && !uqGen && !tcEn
		|=> txByte_ff == $past(n2Val_ff)) // see RQ2
		else $error("N2 not the written value");
	a_n2_shared: assert property (ohReq && ohKind == tu_oh_pkg::KIND_N2 && !uqGen && tcEn
		&& !alarmCtrl_ff[tu_oh_pkg::B_TC_UQ] && !traceSize
		|=> txByte_ff == $past(traceMem_ff[{2'h1, n2Ptr_ff}])) // see RQ3
		else $error("shared N2 trace byte wrong");
	a_n2_repeat: assert property (ohReq && ohKind == tu_oh_pkg::KIND_N2 && !uqGen && tcEn
		&& !alarmCtrl_ff[tu_oh_pkg::B_TC_UQ] && traceSize
		|=> txByte_ff[7:2] == $past(n2Val_ff[7:2])) // see RQ4
		else $error("repeated N2 value wrong");
	a_j2_zero: assert property (ohReq && ohKind == tu_oh_pkg::KIND_J2
		&& ohCtrl_ff[tu_oh_pkg::B_TRACE_ZERO] |=> txByte_ff == 8'h00) // see RQ5
		else $error("zero J2 not sent");
	a_rfi_bit: assert property (v5Built
		|=> txByte_ff[4] == $past(alarmCtrl_ff[tu_oh_pkg::B_RFI])) // see RQ6
		else $error("RFI bit mismatch");
	a_server_code: assert property (ohReq && ohKind == tu_oh_pkg::KIND_K4 && !uqPlain
		&& threeBit && alarmCtrl_ff[tu_oh_pkg::B_RDI_SERV]
		|=> txByte_ff[3:1] == 3'h5) // see RQ9
		else $error("server defect code wrong");
	a_single_ignore: assert property (ohReq && ohKind == tu_oh_pkg::KIND_K4 && !uqPlain
		&& !threeBit |=> txByte_ff[3:1] == 3'h0) // see RQ15
		else $error("K4 code sent in single-bit mode");
	a_single_rdi: assert property (v5Built && !threeBit
		|=> txByte_ff[0] == $past(alarmCtrl_ff[tu_oh_pkg::B_RDI_SERV])) // see RQ10
		else $error("single-bit RDI wrong");
	a_parity_flip: assert property (v5Built && parPending_ff
		|=> txByte_ff[7:6] == ~$past(bipIn) ##0 !parPending_ff) // see RQ11
		else $error("parity not inverted once");
	a_parity_arm: assert property (parRise |=> parPending_ff) // see RQ12
		else $error("rise did not arm injection");
	a_tc_unequipped: assert property (ohReq && ohKind == tu_oh_pkg::KIND_N2 && !uqGen && tcEn
		&& alarmCtrl_ff[tu_oh_pkg::B_TC_UQ] |=> txByte_ff == tu_oh_pkg::TC_UNEQ_BYTE) // see RQ13
		else $error("tandem unequipped byte wrong");
	a_v5_source: assert property (ohReq && ohKind == tu_oh_pkg::KIND_V5 && !uqPlain
		&& alarmCtrl_ff[tu_oh_pkg::B_V5_SRC] |=> txByte_ff == $past(v5Val_ff)) // see RQ14
		else $error("V5 register value not sent");

	c_parity_inject: cover property (parRise ##[1:50] v5Built);
	c_tc_shared: cover property (ohReq && ohKind == tu_oh_pkg::KIND_N2 && tcEn && !traceSize);
	c_write_resp: cover property (bvalid_ff && bready);
	c_server_k4: cover property (ohReq && ohKind == tu_oh_pkg::KIND_K4 && k4Code == 3'h5);

endmodule

// >>> test/add_bus_model.sv
// add-bus partner that requests overhead byte slots and captures the answers
`timescale 1ns/1ps
module add_bus_model (
	input wire logic mclk,
	output logic ohReq,
	output logic [2:0] ohKind,
	output logic [1:0] bipIn,
	output logic [7:0] payloadIn,
	input wire logic txValid,
	input wire logic [7:0] txByte
);
	initial begin
		ohReq = 1'b0;
		ohKind = 3'h0;
		bipIn = 2'h0;
		payloadIn = 8'h00;
	end

	// one slot request, then a bounded wait for the byte
	task automatic slot(input logic [2:0] k, input logic [1:0] b, input logic [7:0] p,
		output logic [7:0] y, output bit ok);
		int n;
		ok = 1'b0;
		y = 8'h00;
		ohReq <= 1'b1;
		ohKind <= k;
		bipIn <= b;
		payloadIn <= p;
		@(posedge mclk);
		// released qualifiers must not keep showing the old value
		ohReq <= 1'b0;
		ohKind <= ~k;
		bipIn <= ~b;
		payloadIn <= ~p;
		for (n = 0; n < 4 && !ok; n++) begin
			@(posedge mclk);
			if (txValid === 1'b1) begin
				ok = 1'b1;
				y = txByte;
			end
		end
	endtask
endmodule

// >>> test/tb_tu_oh_insert.sv
// self-checking bench for the add-side tributary overhead inserter
`timescale 1ns/1ps
module tb_tu_oh_insert;
	localparam logic [7:0] OH = tu_oh_pkg::IDX_OH_CTRL;
	localparam logic [7:0] AL = tu_oh_pkg::IDX_ALARM_CTRL;
	localparam logic [7:0] N2R = tu_oh_pkg::IDX_N2_VALUE;
	localparam logic [7:0] V5R = tu_oh_pkg::IDX_V5_VALUE;
	localparam logic [2:0] KP = tu_oh_pkg::KIND_PAYLOAD;
	localparam logic [2:0] KV = tu_oh_pkg::KIND_V5;
	localparam logic [2:0] KJ = tu_oh_pkg::KIND_J2;
	localparam logic [2:0] KN = tu_oh_pkg::KIND_N2;
	localparam logic [2:0] KK = tu_oh_pkg::KIND_K4;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [9:0] awaddr = 10'h000;
	logic [9:0] araddr = 10'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, ohReq, txValid;
	logic [1:0] bresp, rresp, bipIn, lastResp;
	logic [31:0] rdata, lastData;
	logic [2:0] ohKind;
	logic [7:0] payloadIn, txByte;
	int n_fail = 0;
	int cmp_count = 0;

	always #50 mclk = ~mclk;

	tu_oh_insert u_tu_oh_insert (.mclk(mclk), .arst_n(arst_n),
		.awvalid(awvalid), .awaddr(awaddr), .awready(awready),
		.wvalid(wvalid), .wdata(wdata), .wstrb(wstrb), .wready(wready),
		.bvalid(bvalid), .bresp(bresp), .bready(bready),
		.arvalid(arvalid), .araddr(araddr), .arready(arready),
		.rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready),
		.ohReq(ohReq), .ohKind(ohKind), .bipIn(bipIn), .payloadIn(payloadIn),
		.txValid(txValid), .txByte(txByte));

	add_bus_model u_add_bus_model (.mclk(mclk), .ohReq(ohReq), .ohKind(ohKind),
		.bipIn(bipIn), .payloadIn(payloadIn), .txValid(txValid), .txByte(txByte));

	// ****************************************************************
	// drivers and checks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t mismatch got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("mismatches %0d comparisons %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic hang();
		n_fail++;
		$display("ERROR %0t wait ran out", $time);
		summarize();
	endtask

	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		int n;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (n == 20) hang();
		lastResp = bresp;
		bready <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] idx);
		int n;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (n == 20) hang();
		lastResp = rresp;
		lastData = rdata;
		rready <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic sl(input logic [2:0] k, input logic [1:0] b, input logic [7:0] p,
		input logic [7:0] e);
		logic [7:0] y;
		bit ok;
		u_add_bus_model.slot(k, b, p, y, ok);
		if (!ok) hang();
		chk({24'h000000, y}, {24'h000000, e});
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs();
		rd(AL);
		chk(lastData, {24'h000000, tu_oh_pkg::RST_BYTE});
		// parity bit left clear so no injection stays armed for later scenarios
		wr(AL, 8'hf7);
		rd(AL);
		chk(lastData, {24'h000000, 8'hf7 & tu_oh_pkg::ALARM_MASK});
		wr(8'h62, 8'h5a);
		chk({30'h0, lastResp}, {30'h0, tu_oh_pkg::RESP_DECERR});
		rd(8'h62);
		chk({30'h0, lastResp}, {30'h0, tu_oh_pkg::RESP_DECERR});
		wr(AL, 8'h00);
	endtask

	task automatic t_unequip();
		wr(OH, 8'h00);
		sl(KP, 2'h1, 8'h3c, 8'h3c);
		wr(OH, 8'h10);
		sl(KP, 2'h1, 8'h3c, 8'h00);
		sl(KV, 2'h3, 8'h3c, 8'h00);
		sl(KJ, 2'h3, 8'h3c, 8'h00);
		wr(OH, 8'h18);
		wr(V5R, 8'ha5);
		wr(AL, 8'h90);
		sl(KP, 2'h1, 8'h3c, 8'h00);
		sl(KN, 2'h1, 8'h3c, 8'h00);
		sl(KV, 2'h2, 8'h3c, 8'h91);
		sl(KK, 2'h2, 8'h3c, 8'h0a);
		wr(AL, 8'h01);
		sl(KV, 2'h2, 8'h3c, 8'ha5);
		wr(AL, 8'h00);
	endtask

	task automatic t_n2();
		wr(OH, 8'h00);
		wr(N2R, 8'h6b);
		sl(KN, 2'h0, 8'h11, 8'h6b);
		wr(OH, 8'h01);
		wr(AL, 8'h04);
		sl(KN, 2'h0, 8'h11, 8'h6b);
		wr(OH, 8'h04);
		sl(KN, 2'h0, 8'h11, tu_oh_pkg::TC_UNEQ_BYTE);
		wr(AL, 8'h00);
	endtask

	task automatic t_trace();
		do_reset();
		for (int i = 0; i < 64; i++) wr(8'h80 + 8'(i), 8'(i) ^ 8'ha0);
		wr(OH, 8'h04);
		for (int i = 0; i < 20; i++) sl(KJ, 2'h0, 8'h00, 8'(i % 16) ^ 8'ha0);
		for (int i = 0; i < 20; i++) sl(KN, 2'h0, 8'h00, 8'(16 + i % 16) ^ 8'ha0);
		wr(OH, 8'h06);
		sl(KJ, 2'h0, 8'h00, 8'h00);
		do_reset();
		wr(OH, 8'h01);
		for (int i = 0; i < 66; i++) sl(KJ, 2'h0, 8'h00, 8'(i % 64) ^ 8'ha0);
		// n2 pointer still at zero after the reset
		wr(N2R, 8'hb7);
		wr(OH, 8'h05);
		for (int i = 0; i < 16; i++) sl(KN, 2'h0, 8'h00, {6'h2d, tu_oh_pkg::N2_ALIGN[15 - i], 1'b0});
	endtask

	task automatic t_rdi();
		logic [2:0] c;
		logic b8;
		wr(OH, 8'h00);
		wr(V5R, 8'ha5);
		for (int m = 0; m < 2; m++) begin
			wr(tu_oh_pkg::IDX_CONFIG, 8'(m));
			for (int i = 0; i < 16; i++) begin
				wr(AL, {4'(i), 4'h0});
				c = i[0] ? 3'b101 : i[1] ? 3'b110 : i[2] ? 3'b010 : 3'b000;
				b8 = (m == 0) ? (i[0] | i[1]) : i[0];
				sl(KV, 2'h1, 8'h00, {3'b010, i[3], 3'b010, b8});
				sl(KK, 2'h1, 8'h00, {4'h0, (m == 0) ? c : 3'b000, 1'b0});
			end
		end
	endtask

	task automatic t_parity();
		wr(AL, 8'h08);
		repeat (2) @(posedge mclk);
		// status: n2 pointer wrapped to 0, j2 pointer at 2, injection pending
		rd(tu_oh_pkg::IDX_STATUS);
		chk(lastData, 32'h0000_0021);
		sl(KV, 2'h1, 8'h00, 8'h84);
		sl(KV, 2'h1, 8'h00, 8'h44);
		rd(tu_oh_pkg::IDX_STATUS);
		chk(lastData, 32'h0000_0020);
		// rewriting a set bit is not a rise
		wr(AL, 8'h08);
		repeat (2) @(posedge mclk);
		sl(KV, 2'h1, 8'h00, 8'h44);
		wr(AL, 8'h00);
		wr(AL, 8'h08);
		repeat (2) @(posedge mclk);
		sl(KV, 2'h1, 8'h00, 8'h84);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		do_reset();
		t_regs();
		t_unequip();
		t_n2();
		t_trace();
		t_rdi();
		t_parity();
		summarize();
	end
endmodule
